// ===== design/csr_clock_select.sv
// clock source select register and stop mode clock gating
`timescale 1ns/100ps
`default_nettype none
module csr_clock_select #(
  // rc edges to wait before a gated stop is entered
  parameter int STOP_SYNC_CYC = csr_pkg::CSR_STOP_SYNC_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // device status
  input wire logic special_mode_i,
  input wire logic write_protect_i,
  input wire logic wdog_cfg_written_i,
  input wire logic osc_running_i,
  input wire logic osc_pll_qualified_i,
  input wire logic stop_req_i,
  input wire logic full_stop_entry_i,
  input wire logic rc_clk_edge_i,
  // clock control
  output logic stop_ack_o,
  output logic osc_qualified_o,
  output csr_pkg::csr_ctl_t ctl_o
);
  import csr_pkg::*;

  // ==========================================================
  // elaboration checks
  // the rc edge counter is two bits wide, so one to four edges fit
  if (STOP_SYNC_CYC < 1 || STOP_SYNC_CYC > 4) begin : g_bad_sync
    $error("stop sync count out of range");
  end

  // ==========================================================
  // status
  logic osc_qualified_reg;
  logic in_stop_reg;
  logic [7:0] clks_reg;
  logic [7:0] clks_next;
  logic [1:0] rc_cnt_reg;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i)
      osc_qualified_reg <= 1'b0;
    else if (full_stop_entry_i)
      osc_qualified_reg <= 1'b0;
    else
      osc_qualified_reg <= osc_running_i & osc_pll_qualified_i;
  end

  // ==========================================================
  // register write
  logic wr_hit;
  logic [7:0] wr_mask;
  logic [7:0] sw_val;
  assign wr_hit = wr_i && addr_i == CSR_ADDR_CLKS && !write_protect_i;
  // write-once bits lock in normal mode after watchdog config
  assign wr_mask = (special_mode_i || !wdog_cfg_written_i) ? 8'hff : ~CSR_WRONCE_MASK;

  always_comb begin
    sw_val = wr_hit ? ((wdata_i & wr_mask) | (clks_reg & ~wr_mask)) : clks_reg;
    clks_next = sw_val;
    if (!sw_val[CSR_BIT_PLL] && !osc_qualified_reg)
      clks_next[CSR_BIT_PLL] = 1'b1;
    if (!osc_qualified_reg || full_stop_entry_i)
      clks_next[CSR_BIT_PLL] = 1'b1;
    if (!osc_qualified_reg || full_stop_entry_i) begin
      clks_next[CSR_BIT_TXT] = 1'b0;
      clks_next[CSR_BIT_WXT] = 1'b0;
    end
    // bit 4 untouched by status
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i)
      clks_reg <= CSR_RESET_CLKS;
    else
      clks_reg <= clks_next;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i)
      rdata_o <= 8'h00;
    else if (rd_i && addr_i == CSR_ADDR_CLKS)
      rdata_o <= clks_reg;
    else if (rd_i && addr_i == CSR_ADDR_STAT)
      rdata_o <= {7'h00, osc_qualified_reg};
    else
      rdata_o <= 8'h00;
  end

  // ==========================================================
  // stop handling
  logic gated_rc;
  assign gated_rc = clks_reg[CSR_BIT_GATE] && clks_reg[CSR_BIT_WRC];

  // gated rc stop entry waits for rc edges so the watchdog domain sees it; ungated stop is entered at once
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      in_stop_reg <= 1'b0;
      rc_cnt_reg <= 2'h0;
    end else if (!stop_req_i) begin
      in_stop_reg <= 1'b0;
      rc_cnt_reg <= 2'h0;
    end else if (!in_stop_reg) begin
      if (!gated_rc)
        in_stop_reg <= 1'b1;
      else if (rc_clk_edge_i && rc_cnt_reg == 2'(STOP_SYNC_CYC - 1))
        in_stop_reg <= 1'b1;
      if (rc_clk_edge_i)
        rc_cnt_reg <= rc_cnt_reg + 2'h1;
    end
  end

  // ==========================================================
  // outputs
  csr_wsrc_t wsrc;
  logic pseudo;
  always_comb begin
    if (clks_next[CSR_BIT_WRC])
      wsrc = CSR_WSRC_RC;
    else if (clks_next[CSR_BIT_WXT])
      wsrc = CSR_WSRC_XTAL;
    else
      wsrc = CSR_WSRC_IREF;
  end
  assign pseudo = clks_next[CSR_BIT_OSC_RUN];

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctl_o <= '0;
      stop_ack_o <= 1'b0;
      osc_qualified_o <= 1'b0;
    end else begin
      stop_ack_o <= in_stop_reg;
      osc_qualified_o <= osc_qualified_reg;
      ctl_o.sys_clk_from_pll <= clks_next[CSR_BIT_PLL];
      ctl_o.bus_div_by_two <= 1'b1;
      ctl_o.osc_enable <= !in_stop_reg || pseudo;
      // halted tick keeps its count: only the clock is removed
      ctl_o.tick_clk_run <= !in_stop_reg ||
        (pseudo && clks_next[CSR_BIT_TRUN] && clks_next[CSR_BIT_TXT]);
      ctl_o.tick_src_xtal <= clks_next[CSR_BIT_TXT];
      ctl_o.tick_restart <= clks_next[CSR_BIT_TXT] != clks_reg[CSR_BIT_TXT];
      ctl_o.wdog_restart <= (clks_next[CSR_BIT_WRC] != clks_reg[CSR_BIT_WRC]) ||
        (!clks_next[CSR_BIT_WRC] && !clks_reg[CSR_BIT_WRC] &&
         clks_next[CSR_BIT_WXT] != clks_reg[CSR_BIT_WXT]);
      ctl_o.wdog_src <= wsrc;
      if (!in_stop_reg)
        ctl_o.wdog_clk_run <= 1'b1;
      else if (clks_reg[CSR_BIT_WRC])
        ctl_o.wdog_clk_run <= !clks_reg[CSR_BIT_GATE];
      else
        ctl_o.wdog_clk_run <= pseudo && clks_reg[CSR_BIT_WRUN] && clks_reg[CSR_BIT_WXT];
    end
  end

  // ==========================================================
  // checks
  a_pll_forced: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !osc_qualified_reg |=> clks_reg[CSR_BIT_PLL]) else $error("pll select not forced");
  a_pll_clear_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $fell(clks_reg[CSR_BIT_PLL]) |-> $past(osc_qualified_reg)) else $error("pll cleared early");
  a_tick_cleared: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !osc_qualified_reg |=> !clks_reg[CSR_BIT_TXT]) else $error("tick xtal not cleared");
  a_wdog_xt_cleared: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !osc_qualified_reg |=> !clks_reg[CSR_BIT_WXT]) else $error("wdog xtal not cleared");
  a_protect_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (write_protect_i && osc_qualified_reg && !full_stop_entry_i) |=> $stable(clks_reg))
    else $error("protected write took effect");
  a_wrc_restart: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $changed(clks_reg[CSR_BIT_WRC]) |-> ctl_o.wdog_restart) else $error("no wdog restart");
  a_tick_restart: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $changed(clks_reg[CSR_BIT_TXT]) |-> ctl_o.tick_restart) else $error("no tick restart");
  a_wxt_no_restart: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (clks_reg[CSR_BIT_WRC] && $past(clks_reg[CSR_BIT_WRC]) && $changed(clks_reg[CSR_BIT_WXT]))
    |-> !ctl_o.wdog_restart) else $error("bit 0 restarted watchdog");
  a_stop_sync: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (gated_rc && $rose(in_stop_reg)) |-> $past(rc_clk_edge_i)) else $error("stop entry unsynced");
  a_bit4_kept: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!wr_hit && clks_reg[CSR_BIT_WRC]) |=> clks_reg[CSR_BIT_WRC]) else $error("bit 4 lost");

  // ==========================================================
  // output checks
  a_pll_out: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $past(!reset_i) |-> ctl_o.sys_clk_from_pll == clks_reg[CSR_BIT_PLL])
    else $error("system clock select output stale");

  a_bus_div: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $past(!reset_i) |-> ctl_o.bus_div_by_two)
    else $error("bus divider not two");

  a_tick_src: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $past(!reset_i) |-> ctl_o.tick_src_xtal == clks_reg[CSR_BIT_TXT])
    else $error("tick source output stale");

  a_status_out: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $past(!reset_i) |-> osc_qualified_o == $past(osc_qualified_reg))
    else $error("qualified output stale");

  a_wsrc_rc: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    clks_next[CSR_BIT_WRC] |=> ctl_o.wdog_src == CSR_WSRC_RC)
    else $error("watchdog source not rc");

  a_wsrc_xtal: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!clks_next[CSR_BIT_WRC] && clks_next[CSR_BIT_WXT]) |=> ctl_o.wdog_src == CSR_WSRC_XTAL)
    else $error("watchdog source not xtal");

  a_wsrc_iref: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!clks_next[CSR_BIT_WRC] && !clks_next[CSR_BIT_WXT]) |=> ctl_o.wdog_src == CSR_WSRC_IREF)
    else $error("watchdog source not iref");

  // ==========================================================
  // stop mode checks
  a_osc_off_stop: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (in_stop_reg && !clks_next[CSR_BIT_OSC_RUN]) |=> !ctl_o.osc_enable)
    else $error("oscillator left on in full stop");

  a_osc_run: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!in_stop_reg || clks_next[CSR_BIT_OSC_RUN]) |=> ctl_o.osc_enable)
    else $error("oscillator switched off");

  a_wdog_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (in_stop_reg && clks_reg[CSR_BIT_WRC] && clks_reg[CSR_BIT_GATE]) |=> !ctl_o.wdog_clk_run)
    else $error("rc watchdog clock not gated");

  a_wdog_ungated: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (in_stop_reg && clks_reg[CSR_BIT_WRC] && !clks_reg[CSR_BIT_GATE]) |=> ctl_o.wdog_clk_run)
    else $error("rc watchdog clock gated");

  a_stop_wait: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (gated_rc && !in_stop_reg && !rc_clk_edge_i) |=> !in_stop_reg)
    else $error("gated stop entered without rc edge");

  a_ungated_fast: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (stop_req_i && !in_stop_reg && !gated_rc) |=> in_stop_reg)
    else $error("ungated stop entry delayed");

  a_stop_ack: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $past(!reset_i) |-> stop_ack_o == $past(in_stop_reg))
    else $error("stop acknowledge stale");

  a_ack_needs_req: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    stop_ack_o |-> $past(stop_req_i, 2))
    else $error("stop acknowledged without request");

  a_cnt_idle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !stop_req_i |=> rc_cnt_reg == 2'h0)
    else $error("rc edge count kept outside stop");

  a_stop_leave: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !stop_req_i |=> !in_stop_reg)
    else $error("stop kept without request");

  a_tick_run_xtal: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (in_stop_reg && clks_next[CSR_BIT_OSC_RUN] && clks_next[CSR_BIT_TRUN] &&
     clks_next[CSR_BIT_TXT]) |=> ctl_o.tick_clk_run)
    else $error("tick halted in pseudo stop");

  a_tick_halt: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (in_stop_reg && !(clks_next[CSR_BIT_OSC_RUN] && clks_next[CSR_BIT_TRUN] &&
     clks_next[CSR_BIT_TXT])) |=> !ctl_o.tick_clk_run)
    else $error("tick running in stop");

  a_tick_awake: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !in_stop_reg |=> ctl_o.tick_clk_run)
    else $error("tick halted while awake");

  a_wdog_awake: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !in_stop_reg |=> ctl_o.wdog_clk_run)
    else $error("watchdog halted while awake");

  a_wdog_pseudo: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (in_stop_reg && !clks_reg[CSR_BIT_WRC] && clks_next[CSR_BIT_OSC_RUN] &&
     clks_reg[CSR_BIT_WRUN] && clks_reg[CSR_BIT_WXT]) |=> ctl_o.wdog_clk_run)
    else $error("xtal watchdog halted in pseudo stop");

  a_wdog_static: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (in_stop_reg && !clks_reg[CSR_BIT_WRC] &&
     !(clks_reg[CSR_BIT_WRUN] && clks_reg[CSR_BIT_WXT])) |=> !ctl_o.wdog_clk_run)
    else $error("watchdog running in stop");

  // ==========================================================
  // restart checks
  a_tick_pulse: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ctl_o.tick_restart |-> $changed(clks_reg[CSR_BIT_TXT]))
    else $error("tick restart without change");

  a_wdog_pulse_src: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ctl_o.wdog_restart |->
    ($changed(clks_reg[CSR_BIT_WRC]) || (!clks_reg[CSR_BIT_WRC] && $changed(clks_reg[CSR_BIT_WXT]))))
    else $error("watchdog restart without cause");

  a_wxt_restart: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!clks_reg[CSR_BIT_WRC] && !$past(clks_reg[CSR_BIT_WRC]) &&
     $changed(clks_reg[CSR_BIT_WXT])) |-> ctl_o.wdog_restart)
    else $error("bit 0 change did not restart watchdog");

  // ==========================================================
  // register checks
  a_wxt_needs_qual: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(clks_reg[CSR_BIT_WXT]) |-> $past(osc_qualified_reg))
    else $error("wdog xtal set while unqualified");

  a_txt_needs_qual: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(clks_reg[CSR_BIT_TXT]) |-> $past(osc_qualified_reg))
    else $error("tick xtal set while unqualified");

  a_wrc_set_any: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (wr_hit && wr_mask[CSR_BIT_WRC]) |=> clks_reg[CSR_BIT_WRC] == $past(wdata_i[CSR_BIT_WRC]))
    else $error("bit 4 write lost");

  a_lock_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (wr_hit && !special_mode_i && wdog_cfg_written_i) |=>
    ($stable(clks_reg[CSR_BIT_GATE]) && $stable(clks_reg[CSR_BIT_WRC])))
    else $error("locked bit written");

  a_write_lands: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (wr_hit && osc_qualified_reg && !full_stop_entry_i &&
     (special_mode_i || !wdog_cfg_written_i)) |=> clks_reg == $past(wdata_i))
    else $error("open write did not land");

  a_pll_clear_ok: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (wr_hit && !wdata_i[CSR_BIT_PLL] && osc_qualified_reg && !full_stop_entry_i) |=>
    !clks_reg[CSR_BIT_PLL])
    else $error("pll select clear refused");

  a_pll_stays: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (clks_reg[CSR_BIT_PLL] && !wr_hit) |=> clks_reg[CSR_BIT_PLL])
    else $error("pll select dropped without write");

  a_txt_no_spont: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!clks_reg[CSR_BIT_TXT] && !wr_hit) |=> !clks_reg[CSR_BIT_TXT])
    else $error("tick xtal set without write");

  a_wxt_no_spont: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!clks_reg[CSR_BIT_WXT] && !wr_hit) |=> !clks_reg[CSR_BIT_WXT])
    else $error("wdog xtal set without write");

  a_wrc_no_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!clks_reg[CSR_BIT_WRC] && !wr_hit) |=> !clks_reg[CSR_BIT_WRC])
    else $error("bit 4 set without write");

  a_full_forces: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    full_stop_entry_i |=>
    (clks_reg[CSR_BIT_PLL] && !clks_reg[CSR_BIT_TXT] && !clks_reg[CSR_BIT_WXT]))
    else $error("full stop did not force selects");

  a_qual_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    full_stop_entry_i |=> !osc_qualified_reg)
    else $error("qualified kept through full stop");

  a_qual_rise: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (osc_running_i && osc_pll_qualified_i && !full_stop_entry_i) |=> osc_qualified_reg)
    else $error("qualified status not raised");

  a_qual_needs_osc: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !(osc_running_i && osc_pll_qualified_i) |=> !osc_qualified_reg)
    else $error("qualified without oscillator");

  a_read_clks: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rd_i && addr_i == CSR_ADDR_CLKS) |=> rdata_o == $past(clks_reg))
    else $error("select register read wrong");

  a_read_stat: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rd_i && addr_i == CSR_ADDR_STAT) |=> rdata_o == {7'h00, $past(osc_qualified_reg)})
    else $error("status read wrong");

  a_read_idle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data not cleared");

  a_unmapped: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rd_i && addr_i != CSR_ADDR_CLKS && addr_i != CSR_ADDR_STAT) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ===== shared/csr_pkg.sv
// package for the clock source select register block
package csr_pkg;
  localparam logic [3:0] CSR_ADDR_CLKS = 4'h9;
  localparam logic [3:0] CSR_ADDR_STAT = 4'h0;
  localparam int CSR_BIT_PLL = 7;
  localparam int CSR_BIT_OSC_RUN = 6;
  localparam int CSR_BIT_GATE = 5;
  localparam int CSR_BIT_WRC = 4;
  localparam int CSR_BIT_TRUN = 3;
  localparam int CSR_BIT_WRUN = 2;
  localparam int CSR_BIT_TXT = 1;
  localparam int CSR_BIT_WXT = 0;
  localparam logic [7:0] CSR_RESET_CLKS = 8'h80;
  localparam logic [7:0] CSR_WRONCE_MASK = 8'h31;
  localparam int CSR_STOP_SYNC_CYC = 2;
  localparam int CSR_BUS_DIV = 2;
  typedef enum logic [1:0] {CSR_WSRC_IREF, CSR_WSRC_XTAL, CSR_WSRC_RC} csr_wsrc_t;
  typedef struct packed {
    logic sys_clk_from_pll;
    logic bus_div_by_two;
    logic osc_enable;
    logic tick_clk_run;
    logic tick_restart;
    logic tick_src_xtal;
    logic wdog_clk_run;
    logic wdog_restart;
    logic [1:0] wdog_src;
  } csr_ctl_t;
endpackage

// ===== sim/tb_csr_clock_select.sv
// self-checking bench for the clock source select register block
`timescale 1ns/100ps
`default_nettype none
module tb_csr_clock_select;
  import csr_pkg::*;
  // ========================================
  // stimulus and observation
  localparam logic [31:0] WD = 32'h02031312;
  localparam logic [3:0] TR = 4'b1000;
  localparam logic [3:0] WRS = 4'b1110;
  localparam logic [7:0] SRC = 8'b00011010;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic wp = 1'b0, lk = 1'b0, orun = 1'b0, oq = 1'b0;
  logic stop_i = 1'b0, fstop = 1'b0, rce = 1'b0, ack, qual;
  csr_ctl_t ctl;
  int err_total = 0;
  int n_tests = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  // special mode stays low: the normal-mode write lock is the harder case
  csr_clock_select dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .special_mode_i(1'b0),
    .write_protect_i(wp), .wdog_cfg_written_i(lk), .osc_running_i(orun),
    .osc_pll_qualified_i(oq), .stop_req_i(stop_i), .full_stop_entry_i(fstop),
    .rc_clk_edge_i(rce), .stop_ack_o(ack), .osc_qualified_o(qual), .ctl_o(ctl));
  // ========================================
  // shared tasks
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // returns in the cycle after the write edge, where restart pulses stand
  task automatic wr(input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= CSR_ADDR_CLKS;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, rdata_o, e);
  endtask
  task automatic rc_pulse();
    @(posedge ref_clk_i);
    rce <= 1'b1;
    @(posedge ref_clk_i);
    rce <= 1'b0;
    cyc(2);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ========================================
  // scenarios
  task automatic t_reset();
    rd(CSR_ADDR_CLKS, 8'h80, "clks_reset");
    chk("pll_sel", ctl.sys_clk_from_pll, 8'h01);
    chk("bus_div", ctl.bus_div_by_two, 8'h01);
    rd(4'h3, 8'h00, "unmapped");
    rd(CSR_ADDR_STAT, 8'h00, "status");
    $display("reset test done");
  endtask
  // unqualified oscillator: the xtal selects cannot be set, the rc watchdog select can
  task automatic t_unq();
    wr(8'h13);
    chk("wdog_rst", ctl.wdog_restart, 8'h01);
    chk("wdog_src", ctl.wdog_src, 8'h02);
    rd(CSR_ADDR_CLKS, 8'h90, "clks_unq");
    $display("unqualified test done");
  endtask
  task automatic t_stop();
    wr(8'h30);
    rd(CSR_ADDR_CLKS, 8'hb0, "clks_gate");
    stop_i <= 1'b1;
    cyc(4);
    chk("ack_early", ack, 8'h00);
    rc_pulse();
    chk("ack_one_rc", ack, 8'h00);
    rc_pulse();
    for (int i = 0; i < 4 && ack !== 1'b1; i++) cyc(1);
    chk("stop_ack", ack, 8'h01);
    if (ack !== 1'b1) end_of_test();
    chk("wdog_gated", ctl.wdog_clk_run, 8'h00);
    chk("osc_off", ctl.osc_enable, 8'h00);
    chk("tick_halt", ctl.tick_clk_run, 8'h00);
    stop_i <= 1'b0;
    rc_pulse();
    rc_pulse();
    $display("stop test done");
  endtask
  task automatic t_qual();
    orun <= 1'b1;
    oq <= 1'b1;
    cyc(3);
    chk("qualified", qual, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(WD[31-8*i -: 8]);
      chk("tick_rst", ctl.tick_restart, 8'(TR[3-i]));
      chk("wdog_rst", ctl.wdog_restart, 8'(WRS[3-i]));
      chk("wdog_src", ctl.wdog_src, 8'(SRC[7-2*i -: 2]));
      rd(CSR_ADDR_CLKS, WD[31-8*i -: 8], "clks_q");
    end
    chk("pll_off", ctl.sys_clk_from_pll, 8'h00);
    chk("tick_xtal", ctl.tick_src_xtal, 8'h01);
    $display("qualified test done");
  endtask
  task automatic t_pseudo();
    wr(8'h5f);
    rd(CSR_ADDR_CLKS, 8'h5f, "clks_pseudo");
    stop_i <= 1'b1;
    cyc(3);
    chk("stop_ack_p", ack, 8'h01);
    chk("osc_on", ctl.osc_enable, 8'h01);
    chk("tick_run", ctl.tick_clk_run, 8'h01);
    chk("wdog_run", ctl.wdog_clk_run, 8'h01);
    stop_i <= 1'b0;
    cyc(2);
    $display("pseudo stop test done");
  endtask
  task automatic t_full();
    @(posedge ref_clk_i);
    fstop <= 1'b1;
    orun <= 1'b0;
    @(posedge ref_clk_i);
    fstop <= 1'b0;
    cyc(2);
    chk("unqualified", qual, 8'h00);
    chk("pll_forced", ctl.sys_clk_from_pll, 8'h01);
    rd(CSR_ADDR_CLKS, 8'hdc, "clks_full");
    $display("full stop test done");
  endtask
  task automatic t_lock();
    @(posedge ref_clk_i);
    wp <= 1'b1;
    wr(8'h00);
    rd(CSR_ADDR_CLKS, 8'hdc, "clks_write_protect");
    wp <= 1'b0;
    lk <= 1'b1;
    wr(8'h40);
    rd(CSR_ADDR_CLKS, 8'hd0, "clks_lock");
    $display("lock test done");
  endtask
  // ========================================
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_unq();
    t_stop();
    t_qual();
    t_pseudo();
    t_full();
    t_lock();
    end_of_test();
  end
endmodule
`default_nettype wire
